// *** verif/fsp_mem_model.sv ***
// fsp_mem_model: data memory beside the subtract unit; feeds loads, takes stores.
// assumes: load word wanted in the issue cycle; store request is a one-cycle pulse.
`timescale 1ns/1ps
module fsp_mem_model (
	input wire logic core_clk_i,
	input wire logic en_i,
	input wire logic [7:0] raddr_i,
	output logic [31:0] rdata_o,
	input wire logic wr_i,
	input wire logic [7:0] waddr_i,
	input wire logic [31:0] wdata_i
);
	logic [31:0] mem [256];
	initial begin
		foreach (mem[i]) mem[i] = {24'h5A5A5A, i[7:0]};
		mem[0] = 32'h8000_0000;
		mem[1] = 32'h0000_0000;
		mem[2] = 32'hC000_0000;
		mem[3] = 32'h0080_0000;
	end
	// outside a request the bus is not held: show the inverse, not the last word
	assign rdata_o = en_i ? mem[raddr_i] : ~mem[raddr_i];
	always @(posedge core_clk_i) begin
		if (wr_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end
endmodule

// *** verif/fsp_top_monitor.sv ***
// fsp_top_monitor: concurrent checks on the subtract unit's top ports.
// assumes: bound to fsp_top; one clock, active-low asynchronous reset.
`timescale 1ns/1ps
module fsp_top_monitor
	import fsp_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic issue_valid_i,
	input wire logic [15:0] issue_lsw_i,
	input wire logic [15:0] issue_msw_i,
	input wire logic [31:0] load_data_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [31:0] bus_rdata_o,
	input wire logic store_valid_o,
	input wire logic [7:0] store_addr_o,
	input wire logic [FSP_STAT_W-1:0] status_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	// ********
	// issue patterns
	// ********
	sequence s_load;
		issue_valid_i && issue_lsw_i[15:4] == FSP_PFX_SUB_LOAD;
	endsequence
	sequence s_store;
		issue_valid_i && issue_lsw_i[15:4] == FSP_PFX_SUB_STORE;
	endsequence
	// ********
	// checks
	// ********
	load_ni_a: assert property (s_load |=> status_o[FSP_ST_NEG_INT] == $past(load_data_i[31]))
		else $error("negative integer flag wrong");
	load_zi_a: assert property (s_load |=> status_o[FSP_ST_ZERO_INT] == ($past(load_data_i) == 32'h0))
		else $error("zero integer flag wrong");
	load_zf_a: assert property (s_load |=> status_o[FSP_ST_ZERO_FLT] == ($past(load_data_i[30:23]) == 8'h0))
		else $error("zero float flag wrong");
	load_nf_a: assert property (s_load |=> status_o[FSP_ST_NEG_FLT] ==
		($past(load_data_i[31]) && $past(load_data_i[30:23]) != 8'h0))
		else $error("negative float flag wrong");
	test_keep_a: assert property (s_load ##0 !bus_wr_i |=> $stable(status_o[FSP_ST_TEST]))
		else $error("test flag moved by load");
	store_flags_a: assert property (s_store ##0 !bus_wr_i |=> $stable(status_o[FSP_ST_TEST:FSP_ST_NEG_FLT]))
		else $error("store changed a plain flag");
	store_pulse_a: assert property (s_store |=> store_valid_o && store_addr_o == $past(issue_msw_i[7:0]))
		else $error("store request missing");
	store_cause_a: assert property (store_valid_o |-> $past(issue_valid_i && issue_lsw_i[15:4] == FSP_PFX_SUB_STORE))
		else $error("store without store issue");
	over_hold_a: assert property (status_o[FSP_ST_OVF_LATCH] && !bus_wr_i |=> status_o[FSP_ST_OVF_LATCH])
		else $error("overflow latch dropped");
	under_hold_a: assert property (status_o[FSP_ST_UNF_LATCH] && !bus_wr_i |=> status_o[FSP_ST_UNF_LATCH])
		else $error("underflow latch dropped");
	read_idle_a: assert property (!bus_rd_i |=> bus_rdata_o == 32'h0)
		else $error("read data outside its cycle");
endmodule
bind fsp_top fsp_top_monitor fsp_top_monitor_i (.core_clk_i, .rst_b_i, .issue_valid_i, .issue_lsw_i,
	.issue_msw_i, .load_data_i, .bus_wr_i, .bus_rd_i, .bus_rdata_o, .store_valid_o, .store_addr_o, .status_o);

// *** verif/tb.sv ***
// tb: self-checking bench for fsp_top over issue port and register bus.
// assumes: memory side is fsp_mem_model; software keeps delay slots empty.
`timescale 1ns/1ps
module tb;
	import fsp_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic iv = 1'b0;
	logic [15:0] lsw = 16'h0;
	logic [15:0] msw = 16'h0;
	logic [31:0] ld;
	logic [7:0] ba = 8'h0;
	logic [31:0] bd = 32'h0;
	logic bwr = 1'b0;
	logic brd = 1'b0;
	logic [31:0] rdata;
	logic sv;
	logic [7:0] sa;
	logic [31:0] sd;
	logic [FSP_STAT_W-1:0] st;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	logic [31:0] words [4] = '{32'h8000_0000, 32'h0, 32'hC000_0000, 32'h0080_0000};
	logic [31:0] flg [4] = '{32'h058, 32'h068, 32'h054, 32'h040};
	always #5 core_clk_i = ~core_clk_i;
	fsp_top fsp_top_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .issue_valid_i(iv), .issue_lsw_i(lsw),
		.issue_msw_i(msw), .load_data_i(ld), .bus_addr_i(ba), .bus_wdata_i(bd), .bus_wr_i(bwr),
		.bus_rd_i(brd), .bus_rdata_o(rdata), .store_valid_o(sv), .store_addr_o(sa), .store_data_o(sd),
		.status_o(st));
	fsp_mem_model fsp_mem_model_i (.core_clk_i(core_clk_i), .en_i(iv), .raddr_i(msw[7:0]), .rdata_o(ld),
		.wr_i(sv), .waddr_i(sa), .wdata_i(sd));
	// ********
	// helpers
	// ********
	function automatic logic [31:0] pm(input logic [11:0] p, input logic [2:0] d, e, f, a, input logic [7:0] m);
		return {p, f, e[0], e[2:1], d, a, m};
	endfunction
	function automatic logic [7:0] ra(input logic [2:0] i);
		return {3'b001, i, 2'b00};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		bwr <= 1'b1;
		ba <= a;
		bd <= d;
		@(posedge core_clk_i);
		bwr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk_i);
		brd <= 1'b1;
		ba <= a;
		@(posedge core_clk_i);
		brd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic iss(input logic [31:0] op);
		@(posedge core_clk_i);
		iv <= 1'b1;
		lsw <= op[31:16];
		msw <= op[15:0];
		@(posedge core_clk_i);
		iv <= 1'b0;
		#1;
	endtask
	// issue, then read a register in the delay slot
	task automatic slot(input logic [31:0] op, input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk_i);
		iv <= 1'b1;
		lsw <= op[31:16];
		msw <= op[15:0];
		@(posedge core_clk_i);
		iv <= 1'b0;
		brd <= 1'b1;
		ba <= a;
		@(posedge core_clk_i);
		brd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic close_out();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			close_out();
		end
	end
	// ********
	// main sequence
	// ********
	initial begin
		repeat (16) @(posedge core_clk_i);
		chk({22'h0, st}, 32'h0);
		rst_b_i <= 1'b1;
		wr(ra(5), 32'h4040_0000);
		wr(ra(6), 32'h3F80_0000);
		wr(8'h00, 32'h0000_01C0);
		rd(8'h00, 32'h0000_0040);
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0);
		for (int i = 0; i < 4; i++) begin
			// load and subtract targets differ, slot left empty
			slot(pm(FSP_PFX_SUB_LOAD, 3'd7, 3'd5, 3'd6, 3'd4, i[7:0]), ra(i[0] ? 3'd4 : 3'd7),
				i[0] ? words[i] : (i == 0 ? 32'h0 : 32'h4000_0000));
			chk({22'h0, st}, flg[i]);
		end
		rd(ra(7), 32'h4000_0000);
		iss(pm(FSP_PFX_SUB_STORE, 3'd1, 3'd5, 3'd6, 3'd4, 8'hA5));
		chk({23'h0, sv, sa}, 32'h1A5);
		chk(sd, 32'h0080_0000);
		chk({22'h0, st}, 32'h040);
		@(posedge core_clk_i);
		#1;
		chk({31'h0, sv}, 32'h0);
		rd(ra(1), 32'h4000_0000);
		wr(ra(5), 32'h7F7F_FFFF);
		wr(ra(6), 32'hFF7F_FFFF);
		iss(pm(FSP_PFX_SUB_STORE, 3'd2, 3'd5, 3'd6, 3'd4, 8'h00));
		@(posedge core_clk_i);
		#1;
		chk({22'h0, st}, 32'h041);
		rd(ra(2), 32'h7F7F_FFFF);
		wr(8'h00, 32'h0000_0240);
		iss(pm(FSP_PFX_SUB_STORE, 3'd2, 3'd5, 3'd6, 3'd4, 8'h00));
		@(posedge core_clk_i);
		#1;
		chk({22'h0, st}, 32'h241);
		rd(ra(2), 32'h7F80_0000);
		wr(ra(5), 32'h0080_0001);
		wr(ra(6), 32'h0080_0000);
		wr(ra(3), 32'h3F80_0000);
		iss(pm(FSP_PFX_SUB_LOAD, 3'd3, 3'd5, 3'd6, 3'd0, 8'h03));
		@(posedge core_clk_i);
		#1;
		chk({22'h0, st}, 32'h243);
		rd(ra(0), 32'h0080_0000);
		rd(ra(3), 32'h0);
		rd(8'h00, 32'h0000_0243);
		wr(8'h00, 32'h0);
		wr(ra(6), 32'h4000_0001);
		// nothing issued in the delay slot
		slot({FSP_PFX_SUB_IMM, 16'h4000, 2'b00, 3'd6, 3'd2}, ra(2), 32'h7F80_0000);
		rd(ra(2), 32'hB480_0000);
		iss(32'hFFFF_FFFF);
		chk({21'h0, sv, st}, 32'h0);
		close_out();
	end
endmodule

// *** verilog/fsp_fsub.sv ***
// fsp_fsub: combinational single-precision subtract, result = minuend - subtrahend.
// assumes: denormal inputs count as zero; infinities and nans are not special-cased.
`timescale 1ns/1ps
module fsp_fsub
	import fsp_pkg::*;
(
	input wire logic [31:0] minuend_i,
	input wire logic [31:0] subtrahend_i,
	input wire logic round_near_i,
	output logic [31:0] diff_o,
	output logic ovf_o,
	output logic unf_o
);
	logic sa, sb, sl, ss, swap, inc;
	logic [7:0] ea, eb, el, d;
	logic [23:0] ma, mb;
	logic [26:0] xl, sh;
	logic [27:0] sum, n;
	logic [24:0] r;
	logic signed [9:0] e;

	always_comb begin
		sa = minuend_i[31];
		ea = minuend_i[30:23];
		ma = (ea == 8'h00) ? 24'h000000 : {1'b1, minuend_i[22:0]};
		sb = ~subtrahend_i[31];
		eb = subtrahend_i[30:23];
		mb = (eb == 8'h00) ? 24'h000000 : {1'b1, subtrahend_i[22:0]};
		swap = {eb, mb} > {ea, ma};
		sl = swap ? sb : sa;
		ss = swap ? sa : sb;
		el = swap ? eb : ea;
		d = swap ? (eb - ea) : (ea - eb);
		xl = swap ? {mb, 3'b000} : {ma, 3'b000};
		sh = swap ? {ma, 3'b000} : {mb, 3'b000};
		// shifted-out bits fold into the sticky bit so rounding stays exact
		for (int i = 0; i < 27; i++) begin
			if (i < int'(d)) begin
				sh = {1'b0, sh[26:2], sh[1] | sh[0]};
			end
		end
		sum = (sl == ss) ? ({1'b0, xl} + {1'b0, sh}) : ({1'b0, xl} - {1'b0, sh});
		e = signed'({2'b00, el});
		n = sum;
		if (sum[27]) begin
			n = {1'b0, sum[27:2], sum[1] | sum[0]};
			e = e + 10'sd1;
		end else begin
			for (int i = 0; i < 27; i++) begin
				if (!n[26] && (n != 28'h0)) begin
					n = n << 1;
					e = e - 10'sd1;
				end
			end
		end
		// rounding select: 0 truncates toward zero, 1 rounds to nearest even
		inc = round_near_i & n[2] & (n[1] | n[0] | n[3]);
		r = {1'b0, n[26:3]} + {24'h000000, inc};
		if (r[24]) begin
			r = r >> 1;
			e = e + 10'sd1;
		end
		ovf_o = 1'b0;
		unf_o = 1'b0;
		diff_o = {sl, e[7:0], r[22:0]};
		if (n == 28'h0) begin
			diff_o = 32'h0000_0000;
		end else if (e >= 10'sd255) begin
			ovf_o = 1'b1;
			diff_o = round_near_i ? {sl, 8'hFF, 23'h000000} : {sl, 8'hFE, 23'h7FFFFF};
		end else if (e <= 10'sd0) begin
			unf_o = 1'b1;
			diff_o = {sl, 31'h0000_0000};
		end
	end
endmodule

// *** verilog/fsp_pkg.sv ***
// fsp_pkg: constants shared by the floating-point subtract datapath.
// assumes: one core clock, register indices of three bits, single-precision words.
package fsp_pkg;

	// ****************************************************************
	// register file and datapath widths
	// ****************************************************************
	localparam int FSP_NREG = 8;
	localparam int FSP_RW = 3;
	localparam int FSP_DW = 32;
	localparam int FSP_IMM_W = 16;

	// ****************************************************************
	// opcode prefixes (low word)
	// ****************************************************************
	localparam logic [11:0] FSP_PFX_SUB_LOAD = 12'hE32;
	localparam logic [11:0] FSP_PFX_SUB_STORE = 12'hE02;
	localparam logic [7:0] FSP_PFX_SUB_IMM = 8'hE8;

	// ****************************************************************
	// status register bit positions and reset value
	// ****************************************************************
	localparam int FSP_STAT_W = 10;
	localparam int FSP_ST_OVF_LATCH = 0;
	localparam int FSP_ST_UNF_LATCH = 1;
	localparam int FSP_ST_NEG_FLT = 2;
	localparam int FSP_ST_ZERO_FLT = 3;
	localparam int FSP_ST_NEG_INT = 4;
	localparam int FSP_ST_ZERO_INT = 5;
	localparam int FSP_ST_TEST = 6;
	localparam int FSP_ST_RND = 9;
	localparam logic [FSP_STAT_W-1:0] FSP_STAT_RST = 10'h000;
	localparam logic [FSP_STAT_W-1:0] FSP_STAT_WMASK = 10'h27F;

	// ****************************************************************
	// register bus map
	// ****************************************************************
	localparam int FSP_AW = 8;
	localparam logic [7:0] FSP_ADDR_STATUS = 8'h00;
	localparam logic [2:0] FSP_FREG_PAGE = 3'h1;

	// ****************************************************************
	// decoded operation kinds
	// ****************************************************************
	typedef enum logic [1:0] {
		FSP_OP_NONE,
		FSP_OP_SUB_LOAD,
		FSP_OP_SUB_STORE,
		FSP_OP_SUB_IMM
	} fsp_op_t;

endpackage

// *** verilog/fsp_regfile.sv ***
// fsp_regfile: eight 32-bit floating-point registers, several write and read ports.
// assumes: higher-numbered write ports win on the same register; reads see the old value.
`timescale 1ns/1ps
module fsp_regfile
	import fsp_pkg::*;
#(
	parameter int NW = 3,
	parameter int NR = 4
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	fsp_rf_if.mem rf
);
	logic [31:0] mem_reg [FSP_NREG];
	logic [31:0] mem_next [FSP_NREG];
	logic [31:0] rd_reg [NR];
	logic [31:0] rd_next [NR];

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		mem_next = mem_reg;
		for (int w = 0; w < NW; w++) begin
			if (rf.we[w]) begin
				mem_next[rf.waddr[w]] = rf.wdata[w];
			end
		end
		// a substitute word lets the caller put non-register data on the same registered read path
		for (int r = 0; r < NR; r++) begin
			rd_next[r] = rf.rovr_en[r] ? rf.rovr_data[r] : mem_reg[rf.raddr[r]];
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < FSP_NREG; i++) begin
				mem_reg[i] <= 32'h0000_0000;
			end
			for (int r = 0; r < NR; r++) begin
				rd_reg[r] <= 32'h0000_0000;
			end
		end else begin
			mem_reg <= mem_next;
			rd_reg <= rd_next;
		end
	end

	always_comb begin
		for (int r = 0; r < NR; r++) begin
			rf.rdata[r] = rd_reg[r];
		end
	end
endmodule

// *** verilog/fsp_rf_if.sv ***
// fsp_rf_if: write and read ports between the datapath and its register file.
// assumes: one clock; port counts are set by the instantiating module.
`timescale 1ns/1ps
interface fsp_rf_if #(
	parameter int NW = 3,
	parameter int NR = 4
);
	logic [NW-1:0] we;
	logic [2:0] waddr [NW];
	logic [31:0] wdata [NW];
	logic [2:0] raddr [NR];
	logic [NR-1:0] rovr_en;
	logic [31:0] rovr_data [NR];
	logic [31:0] rdata [NR];

	modport mem (input we, input waddr, input wdata, input raddr, input rovr_en, input rovr_data, output rdata);
	modport user (output we, output waddr, output wdata, output raddr, output rovr_en, output rovr_data, input rdata);
endinterface

// *** verilog/fsp_top.sv ***
// fsp_top: subtract execution for the floating-point unit: register difference with
// parallel 32-bit load or store, and immediate minus register, with status flag updates.
// assumes: the cpu pipeline issues one instruction per issue_valid_i cycle on this clock,
// hands the load word with the instruction, and keeps the delay-slot hazards out.
//
// Summary of operation
// - immediate subtract takes two pipeline cycles; destination valid after one delay slot.
// - immediate minuend is the 16-bit immediate as upper half, low half zero.
// - load form writes first minus second source and loads a memory word elsewhere.
// - load opcode recognised by low word prefix; second source top three nibble bits.
// - high word holds two first-source bits, destination, move register, memory field.
// - register fields are three bits selecting registers zero through seven.
// - load sets negative float from bit 31; zero exponent sets zero, clears negative.
// - load sets negative integer from bit 31; zero integer only when word is zero.
// - underflow in parallel-move subtract sets the sticky underflow flag.
// - overflow in parallel-move subtract sets the sticky overflow flag.
// - the parallel load lands in one cycle, before the subtract result.
// - parallel-move subtract destination is written after the delay slot.
// - store form subtracts and writes a register's word to memory.
// - store opcode recognised by its own prefix; only sticky flags may change.
`timescale 1ns/1ps
module fsp_top
	import fsp_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic issue_valid_i,
	input wire logic [15:0] issue_lsw_i,
	input wire logic [15:0] issue_msw_i,
	input wire logic [31:0] load_data_i,
	input wire logic [FSP_AW-1:0] bus_addr_i,
	input wire logic [31:0] bus_wdata_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	output logic [31:0] bus_rdata_o,
	output logic store_valid_o,
	output logic [7:0] store_addr_o,
	output logic [31:0] store_data_o,
	output logic [FSP_STAT_W-1:0] status_o
);
	localparam int NW = 3;
	localparam int NR = 4;

	// ****************************************************************
	// decode
	// ****************************************************************
	fsp_op_t op;
	logic [FSP_RW-1:0] dest_sel, first_sel, second_sel, move_sel;
	logic [7:0] mem_field;
	logic [FSP_IMM_W-1:0] upper_half_immediate;

	always_comb begin
		op = FSP_OP_NONE;
		if (issue_valid_i) begin
			if (issue_lsw_i[15:4] == FSP_PFX_SUB_LOAD) begin
				op = FSP_OP_SUB_LOAD;
			end else if (issue_lsw_i[15:4] == FSP_PFX_SUB_STORE) begin
				op = FSP_OP_SUB_STORE;
			end else if (issue_lsw_i[15:8] == FSP_PFX_SUB_IMM) begin
				op = FSP_OP_SUB_IMM;
			end
		end
		upper_half_immediate = {issue_lsw_i[7:0], issue_msw_i[15:8]};
		mem_field = issue_msw_i[7:0];
		move_sel = issue_msw_i[10:8];
		if (op == FSP_OP_SUB_IMM) begin
			dest_sel = issue_msw_i[2:0];
			first_sel = issue_msw_i[5:3];
			second_sel = issue_msw_i[5:3];
		end else begin
			dest_sel = issue_msw_i[13:11];
			first_sel = {issue_msw_i[15:14], issue_lsw_i[0]};
			second_sel = issue_lsw_i[3:1];
		end
	end

	// ****************************************************************
	// register file
	// ****************************************************************
	fsp_rf_if #(.NW(NW), .NR(NR)) rf();

	fsp_regfile #(.NW(NW), .NR(NR)) u_regfile (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.rf(rf)
	);

	// ****************************************************************
	// subtract stage (second pipeline cycle)
	// ****************************************************************
	logic s1_valid_reg, s1_valid_next;
	logic s1_imm_reg, s1_imm_next;
	logic [FSP_RW-1:0] s1_dest_reg, s1_dest_next;
	logic [FSP_IMM_W-1:0] s1_himm_reg, s1_himm_next;
	logic st_valid_reg, st_valid_next;
	logic [7:0] st_addr_reg, st_addr_next;
	logic [FSP_STAT_W-1:0] status_reg, status_next;
	logic [31:0] minuend, diff;
	logic sub_ovf, sub_unf;
	logic bus_is_stat, bus_is_freg;

	// the subtract reads its operands at issue and writes one cycle later, so the
	// destination only changes at the end of the delay slot
	always_comb begin
		s1_valid_next = (op != FSP_OP_NONE);
		s1_imm_next = (op == FSP_OP_SUB_IMM);
		s1_dest_next = dest_sel;
		s1_himm_next = upper_half_immediate;
		st_valid_next = (op == FSP_OP_SUB_STORE);
		st_addr_next = mem_field;
	end

	always_comb begin
		minuend = s1_imm_reg ? {s1_himm_reg, 16'h0000} : rf.rdata[0];
	end

	fsp_fsub u_fsub (
		.minuend_i(minuend),
		.subtrahend_i(rf.rdata[1]),
		.round_near_i(status_reg[FSP_ST_RND]),
		.diff_o(diff),
		.ovf_o(sub_ovf),
		.unf_o(sub_unf)
	);

	// ****************************************************************
	// register file ports
	// ****************************************************************
	always_comb begin
		bus_is_stat = (bus_addr_i == FSP_ADDR_STATUS);
		bus_is_freg = (bus_addr_i[7:5] == FSP_FREG_PAGE) && (bus_addr_i[1:0] == 2'b00);
		// port 0: software preload, lowest priority
		rf.we[0] = bus_wr_i && bus_is_freg;
		rf.waddr[0] = bus_addr_i[4:2];
		rf.wdata[0] = bus_wdata_i;
		// port 1: parallel load lands at the end of the issue cycle
		rf.we[1] = (op == FSP_OP_SUB_LOAD);
		rf.waddr[1] = move_sel;
		rf.wdata[1] = load_data_i;
		// port 2: subtract result, one cycle after issue
		rf.we[2] = s1_valid_reg;
		rf.waddr[2] = s1_dest_reg;
		rf.wdata[2] = diff;
		rf.raddr[0] = first_sel;
		rf.raddr[1] = second_sel;
		rf.raddr[2] = move_sel;
		rf.raddr[3] = bus_addr_i[4:2];
		rf.rovr_en = 4'b0000;
		rf.rovr_data[0] = 32'h0000_0000;
		rf.rovr_data[1] = 32'h0000_0000;
		rf.rovr_data[2] = 32'h0000_0000;
		// bus answer rides the registered read path so it stands only in the next cycle
		rf.rovr_en[3] = !(bus_rd_i && bus_is_freg);
		rf.rovr_data[3] = (bus_rd_i && bus_is_stat) ? {22'h000000, status_reg} : 32'h0000_0000;
	end

	// ****************************************************************
	// status flags
	// ****************************************************************
	always_comb begin
		status_next = status_reg;
		if (bus_wr_i && bus_is_stat) begin
			status_next = bus_wdata_i[FSP_STAT_W-1:0] & FSP_STAT_WMASK;
		end
		// the load word decides its four flags; test flag is never touched here
		if (op == FSP_OP_SUB_LOAD) begin
			status_next[FSP_ST_NEG_FLT] = load_data_i[31];
			status_next[FSP_ST_ZERO_FLT] = 1'b0;
			if (load_data_i[30:23] == 8'h00) begin
				status_next[FSP_ST_ZERO_FLT] = 1'b1;
				status_next[FSP_ST_NEG_FLT] = 1'b0;
			end
			status_next[FSP_ST_NEG_INT] = load_data_i[31];
			status_next[FSP_ST_ZERO_INT] = (load_data_i == 32'h0000_0000);
			if (!(bus_wr_i && bus_is_stat)) begin
				status_next[FSP_ST_TEST] = status_reg[FSP_ST_TEST];
			end
		end
		// sticky flags: a set from the datapath wins over a software clear in the same cycle
		if (s1_valid_reg && sub_unf) begin
			status_next[FSP_ST_UNF_LATCH] = 1'b1;
		end
		if (s1_valid_reg && sub_ovf) begin
			status_next[FSP_ST_OVF_LATCH] = 1'b1;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_valid_reg <= 1'b0;
			s1_imm_reg <= 1'b0;
			s1_dest_reg <= 3'h0;
			s1_himm_reg <= 16'h0000;
			st_valid_reg <= 1'b0;
			st_addr_reg <= 8'h00;
			status_reg <= FSP_STAT_RST;
		end else begin
			s1_valid_reg <= s1_valid_next;
			s1_imm_reg <= s1_imm_next;
			s1_dest_reg <= s1_dest_next;
			s1_himm_reg <= s1_himm_next;
			st_valid_reg <= st_valid_next;
			st_addr_reg <= st_addr_next;
			status_reg <= status_next;
		end
	end

	always_comb begin
		bus_rdata_o = rf.rdata[3];
		store_valid_o = st_valid_reg;
		store_addr_o = st_addr_reg;
		store_data_o = rf.rdata[2];
		status_o = status_reg;
	end
endmodule
